/* logic/thermo_defs.svh */
/*
   Constants for the heater thermostat panel: timing, register offsets,
   field positions and reset values.
   Assumes a 200 MHz system clock and a 1 ms slow tick derived from it.
*/
`ifndef THERMO_DEFS_SVH
`define THERMO_DEFS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define ID_SHOW_MS 16'd3000
`define SET_SHOW_MS 16'd5000
`define HOLD_MENU_MS 16'd3000
`define HOLD_UNIT_MS 16'd6000
`define IDLE_MS 16'd60000
`define ERR_DELAY_MS 16'd20000
`define REPEAT_DELAY_MS 10'd500
`define REPEAT_PERIOD_MS 10'd200

// ----------------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------------
`define ADDR_CTRL 4'h0
`define ADDR_HYST 4'h1
`define ADDR_SETPOINT 4'h2
`define ADDR_UPPER 4'h3
`define ADDR_LOWER 4'h4
`define ADDR_ALARM_HI 4'h5
`define ADDR_ALARM_LO 4'h6
`define ADDR_STATUS 4'h7
`define ADDR_MASK 4'h8
`define ADDR_LIVE 4'h9
`define ADDR_CODE 4'ha

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define CTRL_FAULT_ON_BIT 0
`define CTRL_UNIT_F_BIT 1
`define EV_ALARM_BIT 0
`define EV_SENSOR_ERR_BIT 1
`define EV_HYBRID_BIT 2
`define EV_STORED_BIT 3

// ----------------------------------------------------------------------
// reset values (temperatures in degrees, two's complement)
// ----------------------------------------------------------------------
`define RST_CTRL 2'h0
`define RST_HYST 16'h0002
`define RST_SETPOINT 16'h0005
`define RST_UPPER 16'h0064
`define RST_LOWER 16'h0000
`define RST_ALARM_HI 16'h0190
`define RST_ALARM_LO 16'hffc4
`define RST_CODE 16'h002a
`define CODE_MAX 16'h0063

// ----------------------------------------------------------------------
// menu entries
// ----------------------------------------------------------------------
`define PAR_EXIT 3'h0
`define PAR_SETPOINT 3'h1
`define PAR_HYST 3'h2
`define PAR_UPPER 3'h3
`define PAR_LOWER 3'h4
`define PAR_ALARM_HI 3'h5
`define PAR_ALARM_LO 3'h6

`endif

/* logic/thermo_pkg.sv */
/*
   Types for the heater thermostat panel: panel states, display modes,
   key and display carriers, and the module's whole state record.
   Assumes thermo_defs.svh for the numeric constants.
*/
package thermo_pkg;

   // panel states, gray along id -> temp -> set view -> menu -> value
   typedef enum logic [2:0] {
      st_model    = 3'b000,
      st_temp     = 3'b001,
      st_set_view = 3'b011,
      st_par_num  = 3'b010,
      st_par_val  = 3'b110,
      st_code     = 3'b111,
      st_unit     = 3'b101
   } panel_state_t;

   typedef enum logic [3:0] {
      disp_model       = 4'h0,
      disp_temp        = 4'h1,
      disp_set_label   = 4'h2,
      disp_par_num     = 4'h3,
      disp_par_val     = 4'h4,
      disp_code_prompt = 4'h5,
      disp_unit_c      = 4'h6,
      disp_unit_f      = 4'h7,
      disp_error       = 4'h8,
      disp_exit_marker = 4'h9
   } disp_mode_t;

   typedef struct packed {
      logic prog;
      logic up;
      logic down;
   } keys_t;

   typedef struct packed {
      disp_mode_t mode;
      logic [15:0] value;
   } display_t;

   typedef struct packed {
      panel_state_t st;
      logic [17:0] tick_cnt;
      logic tick;
      logic [15:0] tmr;
      logic [15:0] hold;
      logic [15:0] idle;
      logic [9:0] rep;
      keys_t keys_prev;
      logic [2:0] par;
      logic [15:0] edit;
      logic code_ok;
      logic [15:0] err_cnt;
      logic err_shown;
      logic heat;
      logic ssr;
      logic contact;
      logic hyb_fault;
      logic cut_closed;
      logic alarm;
      logic [1:0] ctrl;
      logic [15:0] hyst;
      logic [15:0] sp;
      logic [15:0] upper;
      logic [15:0] lower;
      logic [15:0] al_hi;
      logic [15:0] al_lo;
      logic [15:0] code;
      logic [3:0] status;
      logic [3:0] mask;
      logic irq;
      display_t disp;
      logic [15:0] rd_data;
   } panel_reg_t;

endpackage

/* logic/thermo_panel.sv */
/*
   Heater on-off thermostat with hybrid relay sequencing, alarm relay,
   front panel state machine and a small register port.
   Assumes keys are debounced and synchronous to clk_in, the temperature
   word is a signed whole-degree value, and the register master follows
   the one-cycle strobe protocol with read data one cycle later.
*/
`include "thermo_defs.svh"

// Notes on behaviour
// - Heater relay turns on when temperature falls below setpoint minus hysteresis.
// - Solid-state path closes first; contact closes only after current flows.
// - Second relay opens to cut heater current on hybrid relay failure.
// - Alarm relay reports over, under temperature, open or shorted sensor.
// - On sensor fault the load relay is held on or off per configuration.
// - After power-on show model code, then temperature after about 3 s.
// - Short program press shows setpoint label and value for about 5 s.
// - Holding program 3 s opens the menu at the setpoint entry.
// - Holding program a further 3 s shows the temperature unit.
// - Without access code only the setpoint is editable, within its limits.
// - Arrows pick entry, program shows value, arrows change, program stores.
// - Menu closes at the exit marker or after over one minute idle.
// - Protected entry shows code prompt; arrows enter code, program confirms.
// - Accepted access code is revoked after about one minute idle.
// - Held arrow key keeps stepping the edited value.
// - Sensor error code is shown only after persisting 20 seconds.
module thermo_panel #(
   parameter int unsigned TICK_CYCLES = `TICK_CYCLES,
   parameter logic [15:0] MODEL_ID = 16'h00a5 // arbitrary model code
) (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic [15:0] temp_in,
   input wire logic sensor_open_in,
   input wire logic sensor_short_in,
   input wire logic current_ok_in,
   input wire logic hybrid_fail_in,
   input wire thermo_pkg::keys_t keys_in,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rd_data_out,
   output logic load_ssr_out,
   output logic load_contact_out,
   output logic cutoff_relay_out,
   output logic alarm_relay_out,
   output thermo_pkg::display_t disp_out,
   output logic irq_out
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------

   // signed less-than on temperature words
   function automatic logic lt(input logic [15:0] a, input logic [15:0] b);
      return $signed(a) < $signed(b);
   endfunction

   // one step up or down, held inside lo..hi
   function automatic logic [15:0] bump(input logic [15:0] v,
                                        input logic dn,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
      logic [15:0] r;
      r = dn ? 16'(v - 16'h0001) : 16'(v + 16'h0001);
      if (lt(r, lo)) begin
         r = lo;
      end else if (lt(hi, r)) begin
         r = hi;
      end
      return r;
   endfunction

   // saturating increment for the millisecond counters
   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      return (v == 16'hffff) ? v : 16'(v + 16'h0001);
   endfunction

   thermo_pkg::panel_reg_t q;
   thermo_pkg::panel_reg_t n;

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------

   // whole block in one pass; the bus write is applied last so that
   // software wins over a panel store in the same cycle
   always_comb begin
      logic any_key;
      logic prog_rise;
      logic prog_fall;
      logic arrow;
      logic step;
      logic step_dn;
      logic fault;
      logic idle_exp;
      logic [3:0] ev;
      logic [3:0] clr;
      logic [15:0] cur_val;
      logic [15:0] lo;
      logic [15:0] hi;
      any_key = keys_in.prog | keys_in.up | keys_in.down;
      prog_rise = keys_in.prog & ~q.keys_prev.prog;
      prog_fall = ~keys_in.prog & q.keys_prev.prog;
      arrow = keys_in.up | keys_in.down;
      step_dn = keys_in.down & ~keys_in.up;
      fault = sensor_open_in | sensor_short_in;
      idle_exp = q.idle > `IDLE_MS;
      ev = 4'h0;
      clr = 4'h0;
      cur_val = 16'h0000;
      lo = 16'h8000;
      hi = 16'h7fff;
      n = q;
      n.keys_prev = keys_in;

      // 1 ms tick shared by every panel timer
      n.tick = 1'b0;
      if (q.tick_cnt == 18'(TICK_CYCLES - 1)) begin
         n.tick_cnt = 18'h0;
         n.tick = 1'b1;
      end else begin
         n.tick_cnt = 18'(q.tick_cnt + 18'h1);
      end

      // program hold time, idle time and state display time
      if (!keys_in.prog) begin
         n.hold = 16'h0;
      end else if (q.tick) begin
         n.hold = sat_inc(q.hold);
      end
      if (any_key) begin
         n.idle = 16'h0;
      end else if (q.tick) begin
         n.idle = sat_inc(q.idle);
      end
      if (q.tick) begin
         n.tmr = sat_inc(q.tmr);
      end
      if (idle_exp) begin
         n.code_ok = 1'b0;
      end

      // auto repeat: first step on the press edge, then at a fixed rate
      step = arrow & ~(q.keys_prev.up | q.keys_prev.down);
      if (!arrow) begin
         n.rep = 10'h0;
      end else if (q.tick) begin
         if (q.rep == `REPEAT_DELAY_MS) begin
            n.rep = 10'(`REPEAT_DELAY_MS - `REPEAT_PERIOD_MS);
            step = 1'b1;
         end else begin
            n.rep = 10'(q.rep + 10'h1);
         end
      end

      // value of the selected menu entry
      case (q.par)
         `PAR_SETPOINT: cur_val = q.sp;
         `PAR_HYST: cur_val = q.hyst;
         `PAR_UPPER: cur_val = q.upper;
         `PAR_LOWER: cur_val = q.lower;
         `PAR_ALARM_HI: cur_val = q.al_hi;
         `PAR_ALARM_LO: cur_val = q.al_lo;
         default: cur_val = 16'h0000;
      endcase

      // panel state machine
      case (q.st)
         thermo_pkg::st_model: begin
            if (q.tmr >= `ID_SHOW_MS) begin
               n.st = thermo_pkg::st_temp;
            end
         end
         thermo_pkg::st_temp: begin
            if (keys_in.prog && q.hold >= `HOLD_MENU_MS) begin
               n.st = thermo_pkg::st_par_num;
               n.par = `PAR_SETPOINT;
            end else if (prog_fall) begin
               n.st = thermo_pkg::st_set_view;
               n.tmr = 16'h0;
            end
         end
         thermo_pkg::st_set_view: begin
            if (q.tmr >= `SET_SHOW_MS) begin
               n.st = thermo_pkg::st_temp;
            end
         end
         thermo_pkg::st_par_num: begin
            if (idle_exp) begin
               n.st = thermo_pkg::st_temp;
            end else if (keys_in.prog && q.hold >= `HOLD_UNIT_MS) begin
               n.st = thermo_pkg::st_unit;
            end else if (prog_rise) begin
               if (q.par == `PAR_EXIT) begin
                  n.st = thermo_pkg::st_temp;
               end else if (q.par == `PAR_SETPOINT || q.code_ok) begin
                  n.st = thermo_pkg::st_par_val;
                  n.edit = cur_val;
               end else begin
                  n.st = thermo_pkg::st_code;
                  n.edit = 16'h0;
               end
            end else if (step) begin
               // entries wrap, the exit marker sits below the setpoint
               if (step_dn) begin
                  n.par = (q.par == `PAR_EXIT) ? `PAR_ALARM_LO
                                               : 3'(q.par - 3'h1);
               end else begin
                  n.par = (q.par == `PAR_ALARM_LO) ? `PAR_EXIT
                                                   : 3'(q.par + 3'h1);
               end
            end
         end
         thermo_pkg::st_par_val: begin
            if (q.par == `PAR_SETPOINT) begin
               lo = q.lower;
               hi = q.upper;
            end
            if (idle_exp) begin
               n.st = thermo_pkg::st_temp;
            end else if (prog_rise) begin
               n.st = thermo_pkg::st_par_num;
               ev[`EV_STORED_BIT] = 1'b1;
               case (q.par)
                  `PAR_SETPOINT: n.sp = q.edit;
                  `PAR_HYST: n.hyst = q.edit;
                  `PAR_UPPER: n.upper = q.edit;
                  `PAR_LOWER: n.lower = q.edit;
                  `PAR_ALARM_HI: n.al_hi = q.edit;
                  `PAR_ALARM_LO: n.al_lo = q.edit;
                  default: ev[`EV_STORED_BIT] = 1'b0;
               endcase
            end else if (step) begin
               n.edit = bump(q.edit, step_dn, lo, hi);
            end
         end
         thermo_pkg::st_code: begin
            if (idle_exp) begin
               n.st = thermo_pkg::st_temp;
            end else if (prog_rise) begin
               if (q.edit == q.code) begin
                  n.code_ok = 1'b1;
                  n.st = thermo_pkg::st_par_val;
                  n.edit = cur_val;
               end else begin
                  n.st = thermo_pkg::st_par_num;
               end
            end else if (step) begin
               n.edit = bump(q.edit, step_dn, 16'h0, `CODE_MAX);
            end
         end
         thermo_pkg::st_unit: begin
            // unit view lasts while the key is held
            if (!keys_in.prog) begin
               n.st = thermo_pkg::st_par_num;
            end
         end
         default: n.st = thermo_pkg::st_temp;
      endcase

      // sensor error delay; brief glitches never reach the display
      if (!fault) begin
         n.err_cnt = 16'h0;
      end else if (q.tick) begin
         n.err_cnt = sat_inc(q.err_cnt);
      end
      n.err_shown = fault && q.err_cnt >= `ERR_DELAY_MS;
      ev[`EV_SENSOR_ERR_BIT] = n.err_shown & ~q.err_shown;

      // on-off control with hysteresis band
      if (fault) begin
         n.heat = q.ctrl[`CTRL_FAULT_ON_BIT];
      end else if (lt(temp_in, 16'(q.sp - q.hyst))) begin
         n.heat = 1'b1;
      end else if (!lt(temp_in, q.sp)) begin
         n.heat = 1'b0;
      end

      // hybrid fault latches until reset: no further heating after it
      n.hyb_fault = q.hyb_fault | hybrid_fail_in;
      ev[`EV_HYBRID_BIT] = n.hyb_fault & ~q.hyb_fault;
      n.cut_closed = ~n.hyb_fault;
      n.ssr = n.heat & ~n.hyb_fault;
      // contact closes no earlier than a cycle after the ssr and opens with it, so it never makes first
      n.contact = q.ssr & n.ssr & current_ok_in;

      // alarm on thresholds or sensor fault
      n.alarm = fault | lt(q.al_hi, temp_in) | lt(temp_in, q.al_lo);
      ev[`EV_ALARM_BIT] = n.alarm & ~q.alarm;

      // ----------------------------------------------------------------
      // register port
      // ----------------------------------------------------------------
      n.rd_data = 16'h0;
      if (wr_in) begin
         if (addr_in == `ADDR_CTRL) begin
            n.ctrl = wr_data_in[1:0];
         end else if (addr_in == `ADDR_HYST) begin
            n.hyst = wr_data_in;
         end else if (addr_in == `ADDR_SETPOINT) begin
            n.sp = wr_data_in;
         end else if (addr_in == `ADDR_UPPER) begin
            n.upper = wr_data_in;
         end else if (addr_in == `ADDR_LOWER) begin
            n.lower = wr_data_in;
         end else if (addr_in == `ADDR_ALARM_HI) begin
            n.al_hi = wr_data_in;
         end else if (addr_in == `ADDR_ALARM_LO) begin
            n.al_lo = wr_data_in;
         end else if (addr_in == `ADDR_STATUS) begin
            clr = wr_data_in[3:0];
         end else if (addr_in == `ADDR_MASK) begin
            n.mask = wr_data_in[3:0];
         end else if (addr_in == `ADDR_CODE) begin
            n.code = wr_data_in;
         end
      end
      if (rd_in) begin
         if (addr_in == `ADDR_CTRL) begin
            n.rd_data = {14'h0, q.ctrl};
         end else if (addr_in == `ADDR_HYST) begin
            n.rd_data = q.hyst;
         end else if (addr_in == `ADDR_SETPOINT) begin
            n.rd_data = q.sp;
         end else if (addr_in == `ADDR_UPPER) begin
            n.rd_data = q.upper;
         end else if (addr_in == `ADDR_LOWER) begin
            n.rd_data = q.lower;
         end else if (addr_in == `ADDR_ALARM_HI) begin
            n.rd_data = q.al_hi;
         end else if (addr_in == `ADDR_ALARM_LO) begin
            n.rd_data = q.al_lo;
         end else if (addr_in == `ADDR_STATUS) begin
            n.rd_data = {12'h0, q.status};
         end else if (addr_in == `ADDR_MASK) begin
            n.rd_data = {12'h0, q.mask};
         end else if (addr_in == `ADDR_LIVE) begin
            n.rd_data = {5'h0, q.st, q.cut_closed, q.hyb_fault,
                         q.err_shown, q.code_ok, q.alarm, q.contact,
                         q.ssr, q.heat};
         end else if (addr_in == `ADDR_CODE) begin
            n.rd_data = q.code;
         end
      end

      // sticky status: a new event beats a clear in the same cycle
      n.status = (q.status & ~clr) | ev;
      n.irq = |(n.status & n.mask);

      // display follows the next panel state
      n.disp.value = temp_in;
      case (n.st)
         thermo_pkg::st_model: begin
            n.disp.mode = thermo_pkg::disp_model;
            n.disp.value = MODEL_ID;
         end
         thermo_pkg::st_temp: begin
            if (n.err_shown) begin
               n.disp.mode = thermo_pkg::disp_error;
               n.disp.value = sensor_short_in ? 16'h0001 : 16'h0002;
            end else begin
               n.disp.mode = thermo_pkg::disp_temp;
            end
         end
         thermo_pkg::st_set_view: begin
            n.disp.mode = thermo_pkg::disp_set_label;
            n.disp.value = n.sp;
         end
         thermo_pkg::st_par_num: begin
            n.disp.mode = (n.par == `PAR_EXIT) ? thermo_pkg::disp_exit_marker
                                               : thermo_pkg::disp_par_num;
            n.disp.value = {13'h0, n.par};
         end
         thermo_pkg::st_par_val: begin
            n.disp.mode = thermo_pkg::disp_par_val;
            n.disp.value = n.edit;
         end
         thermo_pkg::st_code: begin
            n.disp.mode = thermo_pkg::disp_code_prompt;
            n.disp.value = n.edit;
         end
         default: begin
            n.disp.mode = n.ctrl[`CTRL_UNIT_F_BIT] ? thermo_pkg::disp_unit_f
                                                   : thermo_pkg::disp_unit_c;
            n.disp.value = 16'h0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------

   // cut relay starts open so no heater current flows before first edge
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         q <= '0;
         q.st <= thermo_pkg::st_model;
         q.ctrl <= `RST_CTRL;
         q.hyst <= `RST_HYST;
         q.sp <= `RST_SETPOINT;
         q.upper <= `RST_UPPER;
         q.lower <= `RST_LOWER;
         q.al_hi <= `RST_ALARM_HI;
         q.al_lo <= `RST_ALARM_LO;
         q.code <= `RST_CODE;
         q.par <= `PAR_SETPOINT;
         q.disp.mode <= thermo_pkg::disp_model;
         q.disp.value <= MODEL_ID;
      end else begin
         q <= n;
      end
   end

   assign rd_data_out = q.rd_data;
   assign load_ssr_out = q.ssr;
   assign load_contact_out = q.contact;
   assign cutoff_relay_out = q.cut_closed;
   assign alarm_relay_out = q.alarm;
   assign disp_out = q.disp;
   assign irq_out = q.irq;

endmodule // thermo_panel

/* verif/thermo_panel_monitor.sv */
/* checker on the thermostat panel ports.
   assumes it is bound to thermo_panel and sees only its ports. */
module thermo_panel_monitor (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic sensor_open_in,
   input wire logic sensor_short_in,
   input wire logic current_ok_in,
   input wire logic hybrid_fail_in,
   input wire logic rd_in,
   input wire logic [15:0] rd_data_out,
   input wire logic load_ssr_out,
   input wire logic load_contact_out,
   input wire logic cutoff_relay_out,
   input wire logic alarm_relay_out,
   input wire thermo_pkg::display_t disp_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // bypass contact only after current flows on the solid-state path
   property p_contact_late;
      $rose(load_contact_out) |-> $past(load_ssr_out) && $past(current_ok_in);
   endproperty
   a_contact_late: assert property (p_contact_late)
      else $error("contact closed before current");
   property p_contact_ssr;
      load_contact_out |-> load_ssr_out;
   endproperty
   a_contact_ssr: assert property (p_contact_ssr)
      else $error("contact without solid-state path");
   // a failed hybrid switch must cut the current next cycle
   property p_hyb_cut;
      hybrid_fail_in |=> !cutoff_relay_out && !load_ssr_out;
   endproperty
   a_hyb_cut: assert property (p_hyb_cut)
      else $error("heater not cut on hybrid failure");
   property p_cut_contact;
      !cutoff_relay_out |-> !load_contact_out;
   endproperty
   a_cut_contact: assert property (p_cut_contact)
      else $error("contact closed while cut relay open");
   property p_alarm_fault;
      sensor_open_in || sensor_short_in |=> alarm_relay_out;
   endproperty
   a_alarm_fault: assert property (p_alarm_fault)
      else $error("no alarm on sensor fault");
   // read data stands one cycle only
   property p_rd_idle;
      !rd_in |=> rd_data_out == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data without read");
   // error code must not appear right away
   property p_err_late;
      $rose(sensor_open_in) |=>
         (disp_out.mode != thermo_pkg::disp_error) [*8];
   endproperty
   a_err_late: assert property (p_err_late)
      else $error("error shown too early");
   property p_model_first;
      $rose(reset_n_in) |-> (disp_out.mode == thermo_pkg::disp_model) [*8];
   endproperty
   a_model_first: assert property (p_model_first)
      else $error("model code not shown after reset");
endmodule // thermo_panel_monitor

bind thermo_panel thermo_panel_monitor u_mon (.clk_in, .reset_n_in,
   .sensor_open_in, .sensor_short_in, .current_ok_in, .hybrid_fail_in,
   .rd_in, .rd_data_out, .load_ssr_out, .load_contact_out,
   .cutoff_relay_out, .alarm_relay_out, .disp_out);

/* verif/heater_plant.sv */
/* heater current model behind the load relay.
   assumes the solid-state output switches the load directly. */
module heater_plant #(
   parameter int DELAY = 3
) (
   input wire logic clk_in,
   input wire logic ssr_in,
   output logic current_ok_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   // current needs a few cycles to build, so the contact must wait
   always @(posedge clk_in) begin
      cnt <= ssr_in ? cnt + 1 : 0;
   end
   assign current_ok_out = ssr_in && (cnt >= DELAY);
endmodule // heater_plant

/* verif/heater_onoff_thermostat_panel_tb_top.sv */
/* self-checking bench for the thermostat panel.
   assumes a short tick (2 clocks) so panel timeouts stay brief. */
module heater_onoff_thermostat_panel_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam thermo_pkg::keys_t k_prog = 3'b100, k_up = 3'b010;
   logic clk_in = 0, reset_n_in = 0, sensor_open_in = 0;
   logic sensor_short_in = 0, hybrid_fail_in = 0, wr_in = 0, rd_in = 0;
   logic [15:0] temp_in = 16'h0014, wr_data_in = 0, rd_data_out, q;
   logic [3:0] addr_in = 0;
   thermo_pkg::keys_t keys_in = '0;
   thermo_pkg::display_t disp_out;
   logic current_ok, load_ssr_out, load_contact_out;
   logic cutoff_relay_out, alarm_relay_out, irq_out;
   int n_fail = 0, samples_checked = 0, cyc_cnt = 0;
   thermo_panel #(.TICK_CYCLES(2)) u_dut (.clk_in, .reset_n_in, .temp_in,
      .sensor_open_in, .sensor_short_in, .current_ok_in(current_ok),
      .hybrid_fail_in, .keys_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
      .rd_data_out, .load_ssr_out, .load_contact_out, .cutoff_relay_out,
      .alarm_relay_out, .disp_out, .irq_out);
   heater_plant u_plant (.clk_in, .ssr_in(load_ssr_out),
      .current_ok_out(current_ok));
   always #2.5 clk_in = ~clk_in;
   // hang guard, well above the ~28k cycles the run needs
   always @(posedge clk_in) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 40000) begin
         n_fail++;
         give_verdict;
      end
   end
   task give_verdict;
      $display("checks %0d fails %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // waits land 1 ns past the edge so outputs have settled
   task cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 d = rd_data_out;
   endtask
   task press(input thermo_pkg::keys_t k, input int n);
      @(posedge clk_in);
      keys_in <= k;
      repeat (n) @(posedge clk_in);
      keys_in <= '0;
      cyc(4);
   endtask
   task set_temp(input logic [15:0] v);
      @(posedge clk_in);
      temp_in <= v;
      cyc(3);
   endtask
   task t_reset_values;
      logic [3:0] a[9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8,
         4'ha, 4'hb};
      logic [15:0] v[9] = '{16'h2, 16'h5, 16'h64, 16'h0, 16'h190,
         16'hffc4, 16'h0, 16'h2a, 16'h0};
      wr(4'hb, 16'h1234); // unmapped, must be dropped
      for (int i = 0; i < 9; i++) begin
         rd(a[i], q);
         chk(q, v[i]);
      end
   endtask
   task t_panel;
      cyc(6000);
      chk(disp_out.mode, thermo_pkg::disp_temp);
      press(k_prog, 2);
      chk(disp_out.mode, thermo_pkg::disp_set_label);
      chk(disp_out.value, 16'h0005);
      cyc(10010);
      chk(disp_out.mode, thermo_pkg::disp_temp);
      @(posedge clk_in);
      keys_in <= k_prog;
      cyc(6010);
      chk(disp_out.mode, thermo_pkg::disp_par_num);
      chk(disp_out.value, 16'h0001);
      cyc(6000);
      chk(disp_out.mode, thermo_pkg::disp_unit_c);
      press(k_prog, 1);
      press(k_prog, 2);
      chk(disp_out.mode, thermo_pkg::disp_par_val);
      press(k_up, 2);
      chk(disp_out.value, 16'h0006);
      press(k_prog, 2);
      chk(disp_out.mode, thermo_pkg::disp_par_num);
      rd(4'h2, q);
      chk(q, 16'h0006);
      press(k_up, 2);
      press(k_prog, 2);
      chk(disp_out.mode, thermo_pkg::disp_code_prompt);
      press(k_prog, 2);
      chk(disp_out.mode, thermo_pkg::disp_par_num);
   endtask
   task t_heat;
      wr(4'h2, 16'h5);
      wr(4'h1, 16'h2);
      set_temp(16'h3);
      chk(load_ssr_out, 1'b0);
      set_temp(16'h2);
      chk(load_ssr_out, 1'b1);
      cyc(6);
      chk(load_contact_out, 1'b1);
      set_temp(16'h4);
      chk(load_ssr_out, 1'b1);
      set_temp(16'h5);
      chk(load_ssr_out, 1'b0);
      chk(load_contact_out, 1'b0);
   endtask
   // fault with mask clear, then unmask, then clear the sticky bits
   task t_alarm;
      wr(4'h0, 16'h1);
      @(posedge clk_in);
      sensor_open_in <= 1'b1;
      cyc(3);
      chk(alarm_relay_out, 1'b1);
      chk(load_ssr_out, 1'b1);
      chk(irq_out, 1'b0);
      wr(4'h8, 16'h1);
      cyc(2);
      chk(irq_out, 1'b1);
      rd(4'h7, q);
      chk(q, 16'h0009);
      @(posedge clk_in);
      sensor_open_in <= 1'b0;
      wr(4'h7, 16'h000f);
      cyc(2);
      chk(irq_out, 1'b0);
      chk(alarm_relay_out, 1'b0);
   endtask
   task t_hybrid;
      set_temp(16'h2);
      chk(cutoff_relay_out, 1'b1);
      @(posedge clk_in);
      hybrid_fail_in <= 1'b1;
      cyc(2);
      chk(cutoff_relay_out, 1'b0);
      chk(load_ssr_out, 1'b0);
   endtask
   initial begin
      repeat (4) @(posedge clk_in);
      reset_n_in <= 1'b1;
      cyc(1);
      chk(disp_out.mode, thermo_pkg::disp_model);
      t_reset_values;
      t_panel;
      t_heat;
      t_alarm;
      t_hybrid;
      give_verdict;
   end
endmodule // heater_onoff_thermostat_panel_tb_top
